/* core/sync_holdover_consts.vh */
`ifndef SYNC_HOLDOVER_CONSTS_VH
`define SYNC_HOLDOVER_CONSTS_VH
// source select codes
`define SRC_PPS 2'h0
`define SRC_NET 2'h1
`define SRC_TCODE 2'h2
// time code format select
`define FMT_A 1'b0
`define FMT_B 1'b1
// nominal increment in 1/2^24 ns units: 25 ns per cycle
`define FRAC_BITS 24
`define INC_NOM 32'h19000000
// max slew 100 ppm of the nominal increment, in ppm
`define SLEW_PPM 100
// trim step applied to increment per reference edge
`define TRIM_STEP 32'h00000010
// time advance per pulse per second edge, in ns
`define PPS_NS 32'h3b9aca00
// reference lost when no edge within this many ns (1.5 s)
`define LOSS_NS 1500000000
`define LOSS_CYC (`LOSS_NS / 25)
// time code frame edges: format a 1 kHz, format b 100 Hz (ns)
`define PER_A_NS 1000000
`define PER_B_NS 10000000
// states
`define ST_ACQ 2'h0
`define ST_LOCK 2'h1
`define ST_HOLD 2'h2
`define ST_SLEW 2'h3
`endif

/* core/sync_holdover_timebase.v */
`timescale 1ns/100ps
`include "sync_holdover_consts.vh"
// states: acquire waits for the first edge, lock trims the rate,
// holdover free runs on the trimmed rate, slew walks the phase back.
// time_reg counts ns with a hidden 24 bit fraction, so the trim can be
// far finer than one ns per cycle without drifting.
// every step onto the reference lands on the value the reference will
// have after the edge, so lock sees a zero error on a clean source.
module sync_holdover_timebase #(
  parameter LOSS_CYCLES = `LOSS_CYC,
  parameter PER_A_CYC = `PER_A_NS / 25,
  parameter PER_B_CYC = `PER_B_NS / 25
) (
  input wire ref_clk,
  input wire nrst,
  input wire [1:0] src_sel,
  input wire option_fitted,
  input wire tcode_fmt,
  input wire pps_in,
  input wire net_tick,
  input wire [63:0] net_time,
  input wire tcode_in,
  input wire [63:0] restart_limit,
  output reg [63:0] time_reg,
  output reg lost_event_reg,
  output reg hard_resync_reg,
  output reg slewing_reg,
  output reg locked_reg,
  output reg [1:0] state_reg
);

  // ----------------------------------------------------------------
  // reference edge detection
  // ----------------------------------------------------------------
  localparam [31:0] SLEW_MAX = (`INC_NOM / 1000000) * `SLEW_PPM;
  localparam [31:0] ONE_SEC = `PPS_NS; // ns per pps edge

  reg pps_d_reg;
  reg tc_d_reg;
  reg [31:0] tc_cnt_reg;
  reg [31:0] gap_reg;
  reg [63:0] ref_time_reg;
  reg [31:0] inc_reg;
  reg [31:0] trim_reg;
  reg [23:0] frac_reg;
  reg [31:0] tc_per;
  reg ref_edge;
  reg [63:0] ref_next;

  // the time code is sampled as a level; a rising edge marks a frame
  wire tc_rise = tcode_in & ~tc_d_reg;
  wire pps_rise = pps_in & ~pps_d_reg;
  wire [63:0] err = time_reg - ref_next;
  wire err_neg = err[63];
  wire [63:0] err_abs = err_neg ? (64'h0 - err) : err;

  // loss window test, shared by the gap counter and the two states
  // that watch for a silent reference
  function loss_hit;
    input [31:0] gap;
    begin
      loss_hit = (gap == LOSS_CYCLES[31:0]);
    end
  endfunction

  // frame period of the selected time code format
  always @* begin
    tc_per = (tcode_fmt == `FMT_A) ? PER_A_CYC[31:0] :
      PER_B_CYC[31:0];
  end

  // sources differ only in how an edge is found and what time it
  // carries; everything after this point sees one edge and one time.
  // a time code edge that comes too soon is taken as a glitch, which
  // costs one frame of lock time after a reset but keeps noise out.

  // reference edge and the time it stands for, per source
  always @* begin
    ref_edge = 1'b0;
    ref_next = ref_time_reg;
    case (src_sel)
      `SRC_PPS: begin
        ref_edge = pps_rise;
        ref_next = ref_time_reg + {32'h0, ONE_SEC};
      end
      `SRC_NET: begin
        ref_edge = option_fitted & net_tick;
        ref_next = net_time;
      end
      `SRC_TCODE: begin
        // frame edges only count once the full expected period has passed since the last frame rise
        ref_edge = option_fitted & tc_rise &
          (tc_cnt_reg >= tc_per - 32'h1);
        ref_next = ref_time_reg + {32'h0, tc_per} * 64'h19;
      end
      default: begin
        ref_edge = 1'b0;
        ref_next = ref_time_reg;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  // the sum keeps a 24 bit fraction so trims finer than 1 ns accumulate
  wire [31:0] inc_eff = inc_reg + (slewing_reg ? trim_reg : 32'h0);
  wire [47:0] sum = {24'h0, frac_reg} + {16'h0, inc_eff};
  // the edge stands for the reference at this cycle; the register holds
  // it one cycle later, so one increment is added to land in step
  wire [63:0] ref_step = ref_next + {40'h0, sum[47:24]};

  // limits worth knowing:
  // - the trim in lock is one step per edge, so a large rate error takes
  //   many edges to pull in; holdover starts from whatever trim was met
  // - slew runs at the full 100 ppm until the error changes sign, so the
  //   last error is below one slew step per reference period
  // - a loss during slew drops back to holdover without finishing

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pps_d_reg <= 1'b0;
      tc_d_reg <= 1'b0;
      tc_cnt_reg <= 32'h0;
      gap_reg <= 32'h0;
      ref_time_reg <= 64'h0;
      inc_reg <= `INC_NOM;
      trim_reg <= 32'h0;
      frac_reg <= 24'h0;
      time_reg <= 64'h0;
      lost_event_reg <= 1'b0;
      hard_resync_reg <= 1'b0;
      slewing_reg <= 1'b0;
      locked_reg <= 1'b0;
      state_reg <= `ST_ACQ;
    end else begin
      pps_d_reg <= pps_in;
      tc_d_reg <= tcode_in;
      // frame spacing counter; wraps harmlessly on a dead input
      tc_cnt_reg <= tc_rise ? 32'h0 : tc_cnt_reg + 32'h1;
      lost_event_reg <= 1'b0;
      hard_resync_reg <= 1'b0;
      // free running time base always advances, also in holdover
      frac_reg <= sum[23:0];
      time_reg <= time_reg + {40'h0, sum[47:24]};
      if (ref_edge) begin
        gap_reg <= 32'h0;
        ref_time_reg <= ref_next;
      end else if (!loss_hit(gap_reg)) begin
        // saturate so the loss is seen once and not again on a wrap
        gap_reg <= gap_reg + 32'h1;
      end
      // state updates below override the free running advance above
      case (state_reg)
        `ST_ACQ: begin
          // first lock: step straight onto the reference
          if (ref_edge) begin
            time_reg <= ref_step;
            frac_reg <= 24'h0;
            state_reg <= `ST_LOCK;
            locked_reg <= 1'b1;
          end
        end
        `ST_LOCK: begin
          if (loss_hit(gap_reg)) begin
            // no edge for the whole window: warn once and free run
            lost_event_reg <= 1'b1;
            locked_reg <= 1'b0;
            state_reg <= `ST_HOLD;
          end else if (ref_edge) begin
            // phase error stepped out at each edge while the rate is trimmed; one fixed
            // step per edge so a single noisy edge cannot kick the rate
            time_reg <= ref_step;
            if (err != 64'h0)
              inc_reg <= err_neg ? inc_reg + `TRIM_STEP :
                inc_reg - `TRIM_STEP;
          end
        end
        `ST_HOLD: begin
          // the limit is read at this very edge, so a later write from
          // software only affects the next return of the reference
          if (ref_edge) begin
            if (err_abs < restart_limit) begin
              state_reg <= `ST_SLEW;
              slewing_reg <= 1'b1;
              // full rate slew; smaller errors simply finish sooner
              trim_reg <= err_neg ? SLEW_MAX : 32'h0 - SLEW_MAX;
            end else begin
              // a step breaks the record, which the pulse reports
              time_reg <= ref_step;
              frac_reg <= 24'h0;
              hard_resync_reg <= 1'b1;
              locked_reg <= 1'b1;
              state_reg <= `ST_LOCK;
            end
          end
        end
        `ST_SLEW: begin
          if (loss_hit(gap_reg)) begin
            lost_event_reg <= 1'b1;
            slewing_reg <= 1'b0;
            state_reg <= `ST_HOLD;
          end else if (ref_edge) begin
            // finish when the sign flips or error vanishes; the last
            // sub-step remainder is absorbed with no visible gap
            if (err == 64'h0 || (err_neg == trim_reg[31])) begin
              slewing_reg <= 1'b0;
              locked_reg <= 1'b1;
              time_reg <= ref_step;
              state_reg <= `ST_LOCK;
            end
          end
        end
        default: state_reg <= `ST_ACQ;
      endcase
    end
  end

endmodule

/* testbench/holdover_props.sv */
`timescale 1ns/100ps
module holdover_props (
  input wire ref_clk,
  input wire nrst,
  input wire [63:0] time_reg,
  input wire lost_event_reg,
  input wire hard_resync_reg,
  input wire slewing_reg,
  input wire locked_reg,
  input wire [1:0] state_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_lost_once; lost_event_reg |=> !lost_event_reg; endproperty
  a_lost_once: assert property (p_lost_once) else $error("lost long");
  property p_lost_hold; lost_event_reg |-> state_reg == 2'h2; endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("lost state");
  // free running time must keep its nominal pace, no stall and no jump
  property p_free_run; state_reg == 2'h2 && $past(state_reg) == 2'h2
    |-> (time_reg - $past(time_reg)) inside {[64'd24:64'd26]}; endproperty
  a_free_run: assert property (p_free_run) else $error("holdover pace");
  property p_slew_flag; slewing_reg == (state_reg == 2'h3); endproperty
  a_slew_flag: assert property (p_slew_flag) else $error("slew flag");
  property p_slew_rate; slewing_reg && $past(slewing_reg)
    |-> (time_reg - $past(time_reg)) inside {[64'd24:64'd26]}; endproperty
  a_slew_rate: assert property (p_slew_rate) else $error("slew rate");
  property p_hard_once; hard_resync_reg |=> !hard_resync_reg; endproperty
  a_hard_once: assert property (p_hard_once) else $error("hard long");
  property p_hard_src; hard_resync_reg |-> $past(state_reg) == 2'h2; endproperty
  a_hard_src: assert property (p_hard_src) else $error("hard cause");
  property p_lock_ok; locked_reg |-> state_reg != 2'h2; endproperty
  a_lock_ok: assert property (p_lock_ok) else $error("lock in hold");
endmodule
bind sync_holdover_timebase holdover_props u_props (.ref_clk(ref_clk),
  .nrst(nrst), .time_reg(time_reg), .lost_event_reg(lost_event_reg),
  .hard_resync_reg(hard_resync_reg), .slewing_reg(slewing_reg),
  .locked_reg(locked_reg), .state_reg(state_reg));

/* testbench/ref_source.sv */
`timescale 1ns/100ps
module ref_source #(
  parameter PER = 64
) (
  input wire ref_clk,
  input wire run,
  input wire fmt,
  input wire [63:0] offs,
  output reg [63:0] ref_ns = 64'h0,
  output wire net_tick,
  output wire [63:0] net_time,
  output wire pps_in,
  output wire tcode_in
);
  reg [15:0] cnt = 16'h0;
  reg half = 1'b0;
  // true time runs on while the source is silent
  always @(posedge ref_clk) begin
    ref_ns <= ref_ns + 64'd25;
    half <= (cnt == PER - 1) ? ~half : half;
    cnt <= (cnt == PER - 1) ? 16'h0 : cnt + 16'h1;
  end
  assign net_tick = run && cnt == 16'h0;
  // time is valid only with the tick, garbage otherwise
  assign net_time = net_tick ? ref_ns + offs : ~(ref_ns + offs);
  assign pps_in = run && cnt < 16'h4;
  // format b frames come at twice the spacing of format a
  assign tcode_in = pps_in && (!fmt || half);
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  reg ref_clk = 0, nrst = 0, run = 0, fit = 0, fmt = 0;
  reg [1:0] sel = 2'h1;
  reg [63:0] limit = 64'h0, offs = 64'h0;
  reg [31:0] seed = 32'h0e21;
  wire pps, tick, tc, lost, hard, slew, lock;
  wire [63:0] ntime, tval, rns;
  wire [1:0] st;
  integer failures = 0, n_checks = 0, cyc = 0, nhard = 0, i, f;
  sync_holdover_timebase #(.LOSS_CYCLES(200), .PER_A_CYC(64),
    .PER_B_CYC(128)) dut (.ref_clk(ref_clk), .nrst(nrst), .src_sel(sel),
    .option_fitted(fit), .tcode_fmt(fmt), .pps_in(pps), .net_tick(tick),
    .net_time(ntime), .tcode_in(tc), .restart_limit(limit),
    .time_reg(tval), .lost_event_reg(lost), .hard_resync_reg(hard),
    .slewing_reg(slew), .locked_reg(lock), .state_reg(st));
  ref_source #(.PER(64)) src (.ref_clk(ref_clk), .run(run), .fmt(fmt),
    .offs(offs),
    .ref_ns(rns), .net_tick(tick), .net_time(ntime), .pps_in(pps),
    .tcode_in(tc));
  initial forever #12.5 ref_clk = ~ref_clk;
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // local time close to the true reference plus offset
  function near(input [63:0] a);
    near = (a - rns - offs + 64'd256) < 64'd512;
  endfunction
  task chk(input ok, input [8*16:1] msg);
    n_checks = n_checks + 1;
    if (!ok) begin
      failures = failures + 1;
      $display("unexpected %0t %0s", $time, msg);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task rst;
    @(posedge ref_clk) #2 nrst = 0;
    repeat (12) @(posedge ref_clk);
    #2 nrst = 1;
  endtask
  task lose;
    #2 run = 0;
    i = 0;
    while (lost !== 1'b1 && i < 400) begin @(posedge ref_clk); i++; end
    #2 chk(st === 2'h2, "no holdover");
  endtask
  // hard steps counted for the no-gap check
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (hard === 1'b1) nhard <= nhard + 1;
    if (cyc == 60000) begin failures++; give_verdict; end
  end
  initial begin
    rst;
    #2 run = 1;
    repeat (300) @(posedge ref_clk);
    #2 chk(lock === 1'b0, "lock no option");
    #2 fit = 1;
    i = 0;
    while (lock !== 1'b1 && i < 300) begin @(posedge ref_clk); i++; end
    #2 chk(st === 2'h1 && near(tval), "no lock");
    $display("end of lock test");
    lose;
    seed = lfsr(seed);
    offs = 64'd2 + seed[2:0];
    limit = 64'd1000 + seed[7:0];
    #2 run = 1;
    i = 0;
    while (st !== 2'h3 && i < 300) begin @(posedge ref_clk); i++; end
    while (st !== 2'h1 && i < 20000) begin @(posedge ref_clk); i++; end
    #2 chk(st === 2'h1 && nhard == 0 && near(tval), "slew gap");
    $display("end of slew test");
    lose;
    seed = lfsr(seed);
    offs = 64'd5000 + seed[9:0];
    limit = 64'd100 + seed[7:0];
    #2 run = 1;
    i = 0;
    while (hard !== 1'b1 && i < 300) begin @(posedge ref_clk); i++; end
    #2 chk(nhard == 1 && near(tval), "no hard step");
    $display("end of hard test");
    for (f = 0; f < 2; f++) begin
      rst;
      sel = 2'h2;
      fmt = f[0];
      i = 0;
      while (lock !== 1'b1 && i < 400) begin @(posedge ref_clk); i++; end
      #2 chk(lock === 1'b1, "time code lock");
    end
    $display("end of time code test");
    give_verdict;
  end
endmodule
